// ===== verilog/mui_pkg.sv
/*
 Constants and types shared by the MIDI UART host interface.
 Assumes a 40 MHz system clock; all timing counts derive from it.
*/
package mui_pkg;
    // Clock and link timing
    localparam int CLK_PERIOD_PS = 25000; // 40 MHz system clock
    localparam int BIT_PERIOD_NS = 32000; // One bit at 31.25K baud
    localparam int CYCLES_PER_BIT = (BIT_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int OVERSAMPLE = 16; // Receiver ticks per bit
    localparam int CYCLES_PER_TICK = CYCLES_PER_BIT / OVERSAMPLE;
    localparam int START_CHECK_TICK = 7; // Tick at start bit centre
    localparam int LAST_TICK = OVERSAMPLE - 1;
    localparam int DATA_BITS = 8;

    // Host address decode
    localparam int ADDR_W = 16; // Full ISA address width
    localparam int DECODE_W = 10; // Decoded address bits
    localparam logic OFFS_DATA = 1'b0; // Data port offset
    localparam logic OFFS_CMD = 1'b1; // Command and status offset

    // Status layout
    localparam int STAT_RX_EMPTY_BIT = 7;
    localparam int STAT_TX_FULL_BIT = 6;
    localparam int CMD_ECHO_W = 6;
    localparam logic [5:0] CMD_ECHO_RST = 6'h00;

    // Command codes and acknowledge bytes
    localparam logic [7:0] CMD_UART_ON = 8'h3F;
    localparam logic [7:0] CMD_UART_OFF = 8'hFF;
    localparam logic [4:0] CMD_GROUP_A0 = 5'h14; // A0h..A7h upper five bits
    localparam logic [7:0] CMD_AB = 8'hAB;
    localparam logic [7:0] CMD_AC = 8'hAC;
    localparam logic [7:0] CMD_AD = 8'hAD;
    localparam logic [7:0] CMD_AF = 8'hAF;
    localparam logic [7:0] ACK_BYTE = 8'hFE;
    localparam logic [7:0] REPLY_ZERO = 8'h00;
    localparam logic [7:0] REPLY_AC = 8'h15;
    localparam logic [7:0] REPLY_AD = 8'h01;
    localparam logic [7:0] REPLY_AF = 8'h64;

    // Buffers
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;

    // Serial state machines, Gray coded along the frame
    typedef enum logic [1:0] {
        MUI_IDLE = 2'h0,
        MUI_START = 2'h1,
        MUI_DATA = 2'h3,
        MUI_STOP = 2'h2
    } mui_ser_e;
endpackage : mui_pkg

// ===== verilog/mui_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock; a push and a pop may happen in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module mui_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
    logic [AW-1:0] wr_ptr_reg; // Next slot to fill
    logic [AW-1:0] rd_ptr_reg; // Oldest slot
    logic [AW:0] count_reg; // Words held
    logic push;
    logic pop;

    // Full and empty come straight from the count
    assign o_in_ready = (count_reg != DEPTH[AW:0]);
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Advance a pointer with wrap, depth need not be a power of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    // Storage write
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= bump(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= bump(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : mui_fifo
`default_nettype wire

// ===== verilog/mui_midi_uart.sv
/*
 MIDI UART host interface: two byte ports on a host I/O bus, a
 transmit FIFO, a receive FIFO, command acknowledge emulation and a
 31.25K baud serial link.
 Assumes host strobes are one-cycle pulses synchronous to i_clock
 and that the serial input is already synchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none
module mui_midi_uart (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [9:0] i_midi_port_base,
    input wire logic [15:0] i_io_addr,
    input wire logic i_io_rd,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    output logic o_irq,
    input wire logic i_serial_in_pin,
    output logic o_serial_out_pin
);
    // Host decode
    logic port_hit; // Address lands in our two ports
    logic offs; // Port offset bit
    logic data_wr; // Host write to the data port
    logic data_rd; // Host read of the data port
    logic cmd_wr; // Host write to the command port
    logic stat_rd; // Host read of the status port

    // Mode and command echo
    logic uart_mode_reg; // High in UART mode
    logic [5:0] cmd_echo_reg; // Low bits of last command

    // Acknowledge queue, at most two bytes
    logic [1:0] ack_cnt_reg; // Bytes still to push
    logic [7:0] ack_head_reg; // Next acknowledge byte
    logic [7:0] ack_tail_reg; // Second byte, if any
    logic [8:0] reply; // Second-byte flag and value

    // Receive FIFO, overwrite-on-full makes it unlike the plain FIFO
    logic [7:0] rx_mem [mui_pkg::FIFO_DEPTH];
    logic [3:0] rx_wr_ptr_reg; // Next slot to fill
    logic [3:0] rx_rd_ptr_reg; // Oldest byte
    logic [4:0] rx_count_reg; // Bytes held
    logic [7:0] rx_last_reg; // Most recent byte pushed
    logic rx_empty_flag; // Receive FIFO empty
    logic rx_full; // Receive FIFO full
    logic rx_push; // Byte enters this cycle
    logic [7:0] rx_push_data; // The byte that enters
    logic rx_pop; // Host takes the oldest byte

    // Transmit FIFO hookup
    logic tx_in_ready; // Room in the transmit FIFO
    logic tx_full_flag; // Transmit FIFO full
    logic tx_out_valid; // A byte waits to be sent
    logic [7:0] tx_out_data; // Byte at the head
    logic tx_take; // Serializer takes the head byte

    // Transmitter
    mui_pkg::mui_ser_e tx_state_reg;
    logic [10:0] tx_div_reg; // Cycles within a bit
    logic [2:0] tx_bit_reg; // Data bit index
    logic [7:0] tx_shift_reg; // Bits still to send
    logic tx_bit_end; // Last cycle of a bit

    // Receiver
    mui_pkg::mui_ser_e rx_state_reg;
    logic [6:0] rx_div_reg; // Cycles within a tick
    logic [3:0] rx_tick_reg; // Ticks within a bit
    logic [2:0] rx_bit_reg; // Data bit index
    logic [7:0] rx_shift_reg; // Bits collected
    logic rx_tick; // One oversample tick
    logic rx_bit_mid; // Last tick of a bit slot
    logic rx_done; // Good character this cycle

    // Address decode: bits 9:1 compared, bit 0 picks the port, anything above must be zero
    assign port_hit = (i_io_addr[15:mui_pkg::DECODE_W] == '0) &&
        (i_io_addr[9:1] == i_midi_port_base[9:1]);
    assign offs = i_io_addr[0];
    assign data_wr = i_io_wr && port_hit && (offs == mui_pkg::OFFS_DATA);
    assign data_rd = i_io_rd && port_hit && (offs == mui_pkg::OFFS_DATA);
    assign cmd_wr = i_io_wr && port_hit && (offs == mui_pkg::OFFS_CMD);
    assign stat_rd = i_io_rd && port_hit && (offs == mui_pkg::OFFS_CMD);

    // Reply for emulated commands: bit 8 says a second byte follows
    function automatic logic [8:0] ack_reply(input logic [7:0] cmd);
        if (cmd[7:3] == mui_pkg::CMD_GROUP_A0 || cmd == mui_pkg::CMD_AB) begin
            ack_reply = {1'b1, mui_pkg::REPLY_ZERO};
        end else if (cmd == mui_pkg::CMD_AC) begin
            ack_reply = {1'b1, mui_pkg::REPLY_AC};
        end else if (cmd == mui_pkg::CMD_AD) begin
            ack_reply = {1'b1, mui_pkg::REPLY_AD};
        end else if (cmd == mui_pkg::CMD_AF) begin
            ack_reply = {1'b1, mui_pkg::REPLY_AF};
        end else begin
            ack_reply = {1'b0, mui_pkg::REPLY_ZERO};
        end
    endfunction : ack_reply

    assign reply = ack_reply(i_io_wdata);

    // Mode: emulation after reset, switched only by the two codes
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            uart_mode_reg <= 1'b0;
        end else if (cmd_wr) begin
            if (uart_mode_reg) begin
                // Every other code is dropped in UART mode
                if (i_io_wdata == mui_pkg::CMD_UART_OFF) begin
                    uart_mode_reg <= 1'b0;
                end
            end else if (i_io_wdata == mui_pkg::CMD_UART_ON) begin
                uart_mode_reg <= 1'b1;
            end
        end
    end

    // Command echo seen in the status port, any mode
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_echo_reg <= mui_pkg::CMD_ECHO_RST;
        end else if (cmd_wr) begin
            cmd_echo_reg <= i_io_wdata[5:0];
        end
    end

    // Acknowledge queue; a new command replaces anything unsent
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_cnt_reg <= 2'h0;
            ack_head_reg <= mui_pkg::ACK_BYTE;
            ack_tail_reg <= mui_pkg::REPLY_ZERO;
        end else if (cmd_wr && !uart_mode_reg) begin
            // FEh first, then the reply byte where one exists
            ack_head_reg <= mui_pkg::ACK_BYTE;
            ack_tail_reg <= reply[7:0];
            ack_cnt_reg <= reply[8] ? 2'h2 : 2'h1;
        end else if (rx_push && !rx_done) begin
            // Queue head went into the receive FIFO
            ack_head_reg <= ack_tail_reg;
            ack_cnt_reg <= ack_cnt_reg - 2'h1;
        end
    end

    // Serial bytes win the push slot; acks wait a cycle at most
    assign rx_push = rx_done || (ack_cnt_reg != 2'h0);
    assign rx_push_data = rx_done ? rx_shift_reg : ack_head_reg;
    assign rx_empty_flag = (rx_count_reg == '0);
    assign rx_full = (rx_count_reg == 5'(mui_pkg::FIFO_DEPTH));
    // Any data read pops, so emulation mode can drain its acks too
    assign rx_pop = data_rd && !rx_empty_flag;

    // Receive storage; when full with no pop in the same cycle the newest slot is overwritten
    always_ff @(posedge i_clock) begin
        if (rx_push) begin
            if (rx_full && !rx_pop) begin
                rx_mem[rx_wr_ptr_reg - 4'h1] <= rx_push_data;
            end else begin
                rx_mem[rx_wr_ptr_reg] <= rx_push_data;
            end
        end
    end

    // Receive pointers, count and latest byte
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_wr_ptr_reg <= 4'h0;
            rx_rd_ptr_reg <= 4'h0;
            rx_count_reg <= 5'h00;
            rx_last_reg <= mui_pkg::REPLY_ZERO;
        end else begin
            if (rx_push) begin
                rx_last_reg <= rx_push_data;
            end
            if (rx_push && (!rx_full || rx_pop)) begin
                rx_wr_ptr_reg <= rx_wr_ptr_reg + 4'h1;
            end
            if (rx_pop) begin
                rx_rd_ptr_reg <= rx_rd_ptr_reg + 4'h1;
            end
            if (rx_push && !rx_pop && !rx_full) begin
                rx_count_reg <= rx_count_reg + 5'h01;
            end else if (rx_pop && !rx_push) begin
                rx_count_reg <= rx_count_reg - 5'h01;
            end
        end
    end

    // Interrupt: a push in the same cycle as a read keeps it set
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else if (rx_push) begin
            o_irq <= 1'b1;
        end else if (data_rd) begin
            o_irq <= 1'b0;
        end
    end

    // Read data, registered and held until the next read
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_io_rdata <= 8'h00;
        end else if (stat_rd) begin
            o_io_rdata <= {rx_empty_flag, tx_full_flag, cmd_echo_reg};
        end else if (data_rd) begin
            if (uart_mode_reg) begin
                o_io_rdata <= rx_mem[rx_rd_ptr_reg];
            end else begin
                o_io_rdata <= rx_last_reg;
            end
        end
    end

    // Transmit FIFO: writes count only in UART mode
    mui_fifo #(
        .WIDTH(8),
        .DEPTH(mui_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_in_valid(data_wr && uart_mode_reg),
        .o_in_ready(tx_in_ready),
        .i_in_data(i_io_wdata),
        .o_out_valid(tx_out_valid),
        .i_out_ready(tx_take),
        .o_out_data(tx_out_data)
    );

    // A write to a full FIFO is lost, as the host should poll first
    assign tx_full_flag = !tx_in_ready;
    assign tx_take = (tx_state_reg == mui_pkg::MUI_IDLE) && tx_out_valid;
    assign tx_bit_end = (tx_div_reg == 11'(mui_pkg::CYCLES_PER_BIT - 1));

    // Bit timer; 1280 cycles per bit is exact at 40 MHz
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_div_reg <= 11'h000;
        end else if (tx_state_reg == mui_pkg::MUI_IDLE || tx_bit_end) begin
            tx_div_reg <= 11'h000;
        end else begin
            tx_div_reg <= tx_div_reg + 11'h001;
        end
    end

    // Transmit frame: start, eight bits LSB first, stop
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_state_reg <= mui_pkg::MUI_IDLE;
            tx_bit_reg <= 3'h0;
            tx_shift_reg <= 8'h00;
            o_serial_out_pin <= 1'b1;
        end else begin
            unique case (tx_state_reg)
                mui_pkg::MUI_IDLE: begin
                    o_serial_out_pin <= !tx_take;
                    if (tx_take) begin
                        tx_shift_reg <= tx_out_data;
                        tx_state_reg <= mui_pkg::MUI_START;
                    end
                end
                mui_pkg::MUI_START: begin
                    if (tx_bit_end) begin
                        o_serial_out_pin <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg <= 3'h0;
                        tx_state_reg <= mui_pkg::MUI_DATA;
                    end
                end
                mui_pkg::MUI_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit_reg == 3'(mui_pkg::DATA_BITS - 1)) begin
                            o_serial_out_pin <= 1'b1;
                            tx_state_reg <= mui_pkg::MUI_STOP;
                        end else begin
                            o_serial_out_pin <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                            tx_bit_reg <= tx_bit_reg + 3'h1;
                        end
                    end
                end
                mui_pkg::MUI_STOP: begin
                    if (tx_bit_end) begin
                        tx_state_reg <= mui_pkg::MUI_IDLE;
                    end
                end
            endcase
        end
    end

    // Receiver tick: divider restarts on the start edge so the
    // sample points sit centred in each bit
    assign rx_tick = (rx_div_reg == 7'(mui_pkg::CYCLES_PER_TICK - 1));
    assign rx_bit_mid = rx_tick && (rx_tick_reg == 4'(mui_pkg::LAST_TICK));

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_div_reg <= 7'h00;
        end else if (rx_state_reg == mui_pkg::MUI_IDLE || rx_tick) begin
            rx_div_reg <= 7'h00;
        end else begin
            rx_div_reg <= rx_div_reg + 7'h01;
        end
    end

    // Receive frame; a low stop bit drops the character unseen
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_state_reg <= mui_pkg::MUI_IDLE;
            rx_tick_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            unique case (rx_state_reg)
                mui_pkg::MUI_IDLE: begin
                    rx_tick_reg <= 4'h0;
                    if (!i_serial_in_pin) begin
                        rx_state_reg <= mui_pkg::MUI_START;
                    end
                end
                mui_pkg::MUI_START: begin
                    if (rx_tick) begin
                        if (rx_tick_reg == 4'(mui_pkg::START_CHECK_TICK)) begin
                            // Glitch shorter than half a bit is ignored
                            rx_state_reg <= i_serial_in_pin ? mui_pkg::MUI_IDLE
                                                            : mui_pkg::MUI_DATA;
                            rx_tick_reg <= 4'h0;
                            rx_bit_reg <= 3'h0;
                        end else begin
                            rx_tick_reg <= rx_tick_reg + 4'h1;
                        end
                    end
                end
                mui_pkg::MUI_DATA: begin
                    if (rx_tick) begin
                        rx_tick_reg <= rx_tick_reg + 4'h1;
                    end
                    if (rx_bit_mid) begin
                        rx_shift_reg <= {i_serial_in_pin, rx_shift_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == 3'(mui_pkg::DATA_BITS - 1)) begin
                            rx_state_reg <= mui_pkg::MUI_STOP;
                        end
                    end
                end
                mui_pkg::MUI_STOP: begin
                    if (rx_tick) begin
                        rx_tick_reg <= rx_tick_reg + 4'h1;
                    end
                    if (rx_bit_mid) begin
                        rx_done <= i_serial_in_pin;
                        rx_state_reg <= mui_pkg::MUI_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : mui_midi_uart
`default_nettype wire

// ===== dv/mui_midi_uart_chk.sv
/* Concurrent checks on the MIDI UART host interface ports.
 Assumes one clock and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module mui_midi_uart_chk (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [9:0] i_midi_port_base,
    input wire logic [15:0] i_io_addr,
    input wire logic i_io_rd,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    input wire logic [7:0] o_io_rdata,
    input wire logic o_irq,
    input wire logic i_serial_in_pin,
    input wire logic o_serial_out_pin
);
    logic hit; // Access lands on one of the two ports
    logic [5:0] cmd_reg; // Low bits of the last command
    logic uart_reg; // Mirrored mode
    logic [13:0] fcnt_reg; // Cycle inside an outgoing frame, 0 when idle
    assign hit = (i_io_addr[15:10] == 6'h00) && (i_io_addr[9:1] == i_midi_port_base[9:1]);
    // Mirror of command writes
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_reg <= 6'h00;
            uart_reg <= 1'b0;
        end else if (i_io_wr && hit && i_io_addr[0]) begin
            cmd_reg <= i_io_wdata[5:0];
            if (i_io_wdata == mui_pkg::CMD_UART_ON) begin
                uart_reg <= 1'b1;
            end else if (i_io_wdata == mui_pkg::CMD_UART_OFF) begin
                uart_reg <= 1'b0;
            end
        end
    end
    // Frame position; a start may follow the last stop cycle at once
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fcnt_reg <= 14'h0000;
        end else if ($fell(o_serial_out_pin) && fcnt_reg inside {14'h0000, 14'h3200}) begin
            fcnt_reg <= 14'h0001;
        end else if (fcnt_reg != 14'h0000) begin
            fcnt_reg <= (fcnt_reg == 14'h3200) ? 14'h0000 : fcnt_reg + 14'h0001;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    sequence ack_s;
        ##1 o_irq;
    endsequence
    chk_status_echo: assert property (i_io_rd && hit && i_io_addr[0] |=>
        o_io_rdata[5:0] == cmd_reg) else $error("status echo differs");
    chk_addr_miss: assert property (i_io_rd && !hit |=> $stable(o_io_rdata))
        else $error("read off the ports changed data");
    chk_rdata_hold: assert property (!i_io_rd |=> $stable(o_io_rdata))
        else $error("read data moved without a read");
    chk_reset_state: assert property ($rose(i_rst_b) |-> !o_irq && o_serial_out_pin)
        else $error("outputs wrong after reset");
    chk_start_low: assert property (fcnt_reg != 14'h0000 && fcnt_reg < 14'h0500
        |-> !o_serial_out_pin) else $error("start bit too short");
    chk_stop_high: assert property (fcnt_reg >= 14'h2D00 && fcnt_reg < 14'h3200
        |-> o_serial_out_pin) else $error("stop bit missing");
    chk_cmd_ack: assert property (i_io_wr && hit && i_io_addr[0] && !uart_reg
        |=> ack_s) else $error("no interrupt after emulated command");
    chk_emu_drop: assert property (i_io_wr && hit && !i_io_addr[0] && !uart_reg
        && fcnt_reg == 14'h0000 |=> o_serial_out_pin [*3]) else $error("dropped write sent");
endmodule : mui_midi_uart_chk
bind mui_midi_uart mui_midi_uart_chk CHK (.i_clock, .i_rst_b, .i_midi_port_base, .i_io_addr,
    .i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rdata, .o_irq, .i_serial_in_pin, .o_serial_out_pin);
`default_nettype wire

// ===== dv/mui_midi_peer.sv
/* Far-side MIDI device: sends frames and decodes what it hears.
 Assumes a 40 MHz clock, 1280 cycles a bit. */
`timescale 1ns/1ps
`default_nettype none
module mui_midi_peer (
    input wire logic i_clock,
    input wire logic i_line,
    output logic o_line
);
    logic [7:0] got_q[$]; // Bytes decoded from the device
    initial o_line = 1'b1;
    // One frame; stop level chosen so a broken frame can be sent
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clock);
            #2 o_line = f[i];
            repeat (1279) @(posedge i_clock);
        end
        @(posedge i_clock);
        #2 o_line = 1'b1;
    endtask : send
    // Receiver samples mid-bit, clear of the edges where the line moves
    always begin : rx
        logic [7:0] b;
        @(negedge i_line);
        repeat (640) @(posedge i_clock);
        if (!i_line) begin
            for (int i = 0; i < 8; i++) begin
                repeat (1280) @(posedge i_clock);
                b[i] = i_line;
            end
            repeat (1280) @(posedge i_clock);
            if (i_line) got_q.push_back(b);
        end
    end
endmodule : mui_midi_peer
`default_nettype wire

// ===== dv/mui_midi_uart_tb.sv
/* Self-checking bench for the MIDI UART host interface.
 Assumes the partner model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module mui_midi_uart_tb;
    localparam logic [15:0] DAT = 16'h0330;
    localparam logic [15:0] CMD = 16'h0331;
    logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, sin, sout, irq, uart = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, rdat, v, old, lastp = 8'h00, tbl[8], b0, b1;
    logic [7:0] q[$]; // Model of the receive FIFO
    logic [5:0] echo = 6'h00;
    logic txf = 1'b0;
    int n_errors = 0, compares = 0;
    always #12.5 clk = ~clk;
    mui_midi_uart DUT (.i_clock(clk), .i_rst_b(rst_b), .i_midi_port_base(10'h330),
        .i_io_addr(addr), .i_io_rd(rd), .i_io_wr(wr), .i_io_wdata(wd), .o_io_rdata(rdat),
        .o_irq(irq), .i_serial_in_pin(sin), .o_serial_out_pin(sout));
    mui_midi_peer P (.i_clock(clk), .i_line(sout), .o_line(sin));
    task chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task wr_b(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 {addr, wd, wr} = {a, d, 1'b1};
        @(posedge clk);
        #2 wr = 1'b0;
    endtask : wr_b
    task rd_b(input logic [15:0] a);
        @(posedge clk);
        #2 {addr, rd} = {a, 1'b1};
        @(posedge clk);
        #2 rd = 1'b0;
        v = rdat;
    endtask : rd_b
    // Full receive FIFO keeps its count and takes the newest in the last slot
    task push(input logic [7:0] b);
        if (q.size() == 16) q[15] = b;
        else q.push_back(b);
        lastp = b;
    endtask : push
    task rd_data;
        rd_b(DAT);
        if (uart) chk(v, q.pop_front());
        else chk(v, lastp);
        if (!uart && q.size() > 0) q.pop_front();
    endtask : rd_data
    task stat;
        rd_b(CMD);
        chk(v, {q.size() == 0, txf, echo});
    endtask : stat
    task cmd(input logic [7:0] c);
        wr_b(CMD, c);
        echo = c[5:0];
        if (uart) begin
            if (c == 8'hFF) uart = 1'b0;
        end else begin
            push(8'hFE);
            if (c == 8'h3F) uart = 1'b1;
            if (c[7:3] == 5'h14 || c == 8'hAB) push(8'h00);
            if (c == 8'hAC) push(8'h15);
            if (c == 8'hAD) push(8'h01);
            if (c == 8'hAF) push(8'h64);
        end
    endtask : cmd
    task wait_irq;
        for (int i = 0; i < 20000 && irq !== 1'b1; i++) #25;
        chk({7'h00, irq}, 8'h01);
        if (irq !== 1'b1) report_and_stop;
    endtask : wait_irq
    // Overall limit cuts any hang short
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(95));
        repeat (20) @(posedge clk);
        #2 rst_b = 1'b1;
        stat;
        wr_b(DAT, 8'h55);
        stat;
        $display("test reset and dropped write done");
        tbl = '{8'hA0 + 8'($urandom % 8), 8'hA7, 8'hAB, 8'hAC, 8'hAD, 8'hAF, 8'hA8, 8'h12};
        foreach (tbl[i]) begin
            cmd(tbl[i]);
            wait_irq;
            stat;
            while (q.size() > 0) rd_data;
            rd_data;
            chk({7'h00, irq}, 8'h00);
            stat;
        end
        $display("test emulated commands done");
        old = v;
        rd_b(16'h0730);
        chk(v, old);
        wr_b(16'h1331, 8'h3F);
        stat;
        cmd(8'h3F);
        wait_irq;
        rd_data;
        cmd(8'h2A);
        #100;
        chk({7'h00, irq}, 8'h00);
        stat;
        $display("test mode entry done");
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        fork
            begin
                wr_b(DAT, b0);
                wr_b(DAT, b1);
            end
            begin
                P.send(8'hC5, 1'b1);
                P.send(8'h3A, 1'b1);
            end
        join
        push(8'hC5);
        push(8'h3A);
        wait_irq;
        rd_data;
        rd_data;
        stat;
        for (int i = 0; i < 30000 && P.got_q.size() < 2; i++) @(posedge clk);
        chk(P.got_q.size() > 0 ? P.got_q[0] : 8'hxx, b0);
        chk(P.got_q.size() > 1 ? P.got_q[1] : 8'hxx, b1);
        P.send(8'h77, 1'b0);
        repeat (2000) @(posedge clk);
        stat;
        $display("test serial traffic done");
        cmd(8'hFF);
        repeat (9) cmd(8'hAB);
        cmd(8'h3F);
        wait_irq;
        while (q.size() > 0) rd_data;
        for (int i = 0; i < 18; i++) wr_b(DAT, 8'(i));
        txf = 1'b1;
        stat;
        $display("test mode exit and full transmit done");
        report_and_stop;
    end
endmodule : mui_midi_uart_tb
`default_nettype wire
